//--- core/alws_pkg.sv
// constants, field layouts and carrier types of the waveform sequencer
// assumes a 100 MHz clock and a 32-bit register port with byte addresses
package alws_pkg;
  // ==========================================================
  // timing
  localparam int CLK_NS = 10;
  localparam int GAP_NS = 50;
  localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0] GAP_LOAD = 3'(GAP_CYC - 1);
  localparam logic [30:0] STEP_NS = 31'(CLK_NS);
  localparam logic [31:0] STEP_NS32 = 32'(CLK_NS);

  // ==========================================================
  // register offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_MODE = 8'h04;
  localparam logic [7:0] REG_RUNP = 8'h08;
  localparam logic [7:0] REG_SWCFG = 8'h0c;
  localparam logic [7:0] REG_TRIG = 8'h10;
  localparam logic [7:0] REG_LOAD = 8'h14;
  localparam logic [7:0] REG_STAT = 8'h18;

  // ==========================================================
  // command codes in command register bits 3:0, channel in 15:8
  localparam logic [3:0] CMD_PLOAD = 4'h1;
  localparam logic [3:0] CMD_SLOAD = 4'h2;
  localparam logic [3:0] CMD_APPLY = 4'h3;
  localparam logic [3:0] CMD_START = 4'h4;
  localparam logic [3:0] CMD_STOP = 4'h5;
  localparam int CMD_CH_LSB = 8;
  localparam int MODE_RUN_LSB = 4;
  localparam int TRG_CH_LSB = 8;
  localparam logic GEN_ARB = 1'b1;
  localparam logic [1:0] RUN_FREE = 2'h0;
  localparam logic [1:0] RUN_COUNT = 2'h1;
  localparam logic [1:0] RUN_DUR = 2'h2;

  // ==========================================================
  // load stream layout and limits
  localparam logic [4:0] HDR_LAST = 5'h13;
  localparam logic [4:0] CNT_LAST = 5'h03;
  localparam logic [4:0] PHDR_LAST = 5'h05;
  localparam logic [4:0] VEC_LAST = 5'h07;
  localparam logic [4:0] SENT_LAST = 5'h05;
  localparam logic [31:0] MAX_REPEAT = 32'h0010_0000;
  localparam logic signed [31:0] LEVEL_MAX = 32'sh0262_5a00;
  localparam logic signed [31:0] LEVEL_MIN = -32'sh0262_5a00;

  typedef struct packed {
    logic signed [31:0] level;
    logic sw;
    logic [30:0] dt;
  } alws_vec_t;

  typedef struct packed {
    logic [15:0] base;
    logic [15:0] nvec;
    logic signed [31:0] init;
  } alws_pat_t;

  typedef struct packed {
    logic [15:0] idx;
    logic [31:0] rep;
  } alws_sent_t;

  typedef struct packed {
    logic signed [31:0] level;
    logic [30:0] ramp_ns;
    logic sw;
  } alws_chout_t;
endpackage

//--- core/alws_seq.sv
// arbitrary linear waveform sequencer: loader, sequencer, channel players
// assumes bus inputs synchronous to mclk; analog stage slews each output
// linearly to level over ramp_ns
`timescale 1ns/1ps
module alws_seq #(
  parameter int NCH = 2,
  parameter int DEPTH = 1024,
  parameter int MAXPAT = 16,
  parameter int MAXSEQ = 512
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  output alws_pkg::alws_chout_t [NCH-1:0] ch_out,
  output logic trig_out,
  output logic run_status
);
  localparam int AW = $clog2(DEPTH);
  localparam int PW = (MAXPAT > 1) ? $clog2(MAXPAT) : 1;
  localparam int SW = (MAXSEQ > 1) ? $clog2(MAXSEQ) : 1;
  localparam int CW = (NCH > 1) ? $clog2(NCH) : 1;

  if (NCH < 1 || NCH > 256 || DEPTH < 2 || DEPTH > 65536 ||
      MAXPAT < 1 || MAXPAT > DEPTH || MAXSEQ < 1 || MAXSEQ > 512)
  begin : g_bad_params
    $error("alws_seq: unsupported parameter values");
  end

  // ==========================================================
  // reset release
  logic rs1_reg, rs2_reg;
  wire logic rst_s_n = rs2_reg;

  // two stages so release is clean against mclk
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rs1_reg <= 1'b0;
      rs2_reg <= 1'b0;
    end
    else
    begin
      rs1_reg <= 1'b1;
      rs2_reg <= rs1_reg;
    end
  end

  // ==========================================================
  // register port
  logic gen_reg;
  logic [1:0] runm_reg;
  logic [31:0] runp_reg;
  logic sw_en_reg, sw_idle_reg, trg_en_reg;
  logic [CW-1:0] trg_ch_reg;
  logic err_reg, seq_ok_reg, running_reg;
  logic [NCH-1:0] pat_ok_reg;

  wire logic wr_cmd = ce && bus_wr && bus_addr == alws_pkg::REG_CMD;
  wire logic [3:0] cmd = bus_wdata[3:0];
  wire logic c_pload = wr_cmd && cmd == alws_pkg::CMD_PLOAD;
  wire logic c_sload = wr_cmd && cmd == alws_pkg::CMD_SLOAD;
  wire logic c_apply = wr_cmd && cmd == alws_pkg::CMD_APPLY;
  wire logic c_start = wr_cmd && cmd == alws_pkg::CMD_START;
  wire logic c_stop = wr_cmd && cmd == alws_pkg::CMD_STOP;
  wire logic ld_byte = ce && bus_wr && bus_addr == alws_pkg::REG_LOAD;

  // configuration writes
  always_ff @(posedge mclk or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      gen_reg <= 1'b0;
      runm_reg <= alws_pkg::RUN_FREE;
      runp_reg <= 32'h0000_0000;
      sw_en_reg <= 1'b0;
      sw_idle_reg <= 1'b0;
      trg_en_reg <= 1'b0;
      trg_ch_reg <= '0;
    end
    else if (ce && bus_wr)
    begin
      unique case (bus_addr)
        alws_pkg::REG_MODE:
        begin
          gen_reg <= bus_wdata[0];
          runm_reg <= bus_wdata[alws_pkg::MODE_RUN_LSB +: 2];
        end
        alws_pkg::REG_RUNP: runp_reg <= bus_wdata;
        alws_pkg::REG_SWCFG:
        begin
          sw_en_reg <= bus_wdata[0];
          sw_idle_reg <= bus_wdata[1];
        end
        alws_pkg::REG_TRIG:
        begin
          trg_en_reg <= bus_wdata[0];
          trg_ch_reg <= bus_wdata[alws_pkg::TRG_CH_LSB +: CW];
        end
        default: ;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge mclk or negedge rst_s_n)
  begin
    if (!rst_s_n)
      bus_rdata <= 32'h0000_0000;
    else if (ce)
    begin
      bus_rdata <= 32'h0000_0000;
      if (bus_rd)
      begin
        unique case (bus_addr)
          alws_pkg::REG_MODE:
            bus_rdata <= {26'h0, runm_reg, 3'h0, gen_reg};
          alws_pkg::REG_RUNP: bus_rdata <= runp_reg;
          alws_pkg::REG_SWCFG:
            bus_rdata <= {30'h0, sw_idle_reg, sw_en_reg};
          alws_pkg::REG_TRIG:
            bus_rdata <= 32'({trg_ch_reg, 7'h0, trg_en_reg});
          alws_pkg::REG_STAT:
            bus_rdata <= {16'h0, 8'(pat_ok_reg), 5'h0, seq_ok_reg,
                          err_reg, running_reg};
          default: bus_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================
  // stream loader
  typedef enum logic [5:0] {
    L_IDLE = 6'b000001,
    L_PHDR = 6'b000010,
    L_PAT = 6'b000100,
    L_VEC = 6'b001000,
    L_SHDR = 6'b010000,
    L_SENT = 6'b100000
  } alws_lst_t;

  alws_lst_t lst_reg;
  logic [63:0] sh_reg;
  logic [4:0] fc_reg;
  logic [15:0] cnt_reg, pc_reg, vl_reg, wa_reg;
  logic [CW-1:0] lch_reg;
  logic seq_done_reg;
  logic [SW:0] nseq_reg;
  alws_pkg::alws_vec_t vmem [NCH][DEPTH];
  alws_pkg::alws_pat_t ptab [NCH][MAXPAT];
  alws_pkg::alws_sent_t smem [MAXSEQ];

  wire logic [63:0] sh_n = {sh_reg[55:0], bus_wdata[7:0]};
  wire alws_pkg::alws_vec_t vin = sh_n;
  wire alws_pkg::alws_sent_t sin = sh_n[47:0];
  wire logic [15:0] pc_n = pc_reg + 16'h1;

  // a bad field drops the rest of the stream; the set stays unusable
  always_ff @(posedge mclk or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      lst_reg <= L_IDLE;
      sh_reg <= '0;
      fc_reg <= '0;
      cnt_reg <= '0;
      pc_reg <= '0;
      vl_reg <= '0;
      wa_reg <= '0;
      lch_reg <= '0;
      err_reg <= 1'b0;
      pat_ok_reg <= '0;
      seq_ok_reg <= 1'b0;
      seq_done_reg <= 1'b0;
      nseq_reg <= '0;
    end
    else if (ce)
    begin
      seq_done_reg <= 1'b0;
      if (c_pload)
      begin
        lch_reg <= bus_wdata[alws_pkg::CMD_CH_LSB +: CW];
        pat_ok_reg[bus_wdata[alws_pkg::CMD_CH_LSB +: CW]] <= 1'b0;
        {fc_reg, pc_reg, wa_reg} <= '0;
        err_reg <= 1'b0;
        lst_reg <= L_PHDR;
      end
      else if (c_sload)
      begin
        seq_ok_reg <= 1'b0;
        {fc_reg, pc_reg} <= '0;
        err_reg <= 1'b0;
        lst_reg <= L_SHDR;
      end
      else if (ld_byte && lst_reg != L_IDLE)
      begin
        sh_reg <= sh_n;
        fc_reg <= fc_reg + 5'h1;
        unique case (lst_reg)
          L_PHDR, L_SHDR:
          begin
            if (fc_reg == alws_pkg::CNT_LAST)
              cnt_reg <= sh_n[15:0];
            if (fc_reg > alws_pkg::CNT_LAST && bus_wdata[7:0] != 8'h00)
            begin
              err_reg <= 1'b1;
              lst_reg <= L_IDLE;
            end
            else if (fc_reg == alws_pkg::HDR_LAST)
            begin
              fc_reg <= '0;
              if (cnt_reg == 16'h0 || (lst_reg == L_PHDR ?
                  32'(cnt_reg) > MAXPAT : 32'(cnt_reg) > MAXSEQ))
              begin
                err_reg <= 1'b1;
                lst_reg <= L_IDLE;
              end
              else
                lst_reg <= lst_reg == L_PHDR ? L_PAT : L_SENT;
            end
          end
          L_PAT:
          begin
            if (fc_reg == alws_pkg::PHDR_LAST)
            begin
              fc_reg <= '0;
              ptab[lch_reg][PW'(pc_reg)] <=
                {wa_reg, sh_n[47:32], sh_n[31:0]};
              vl_reg <= sh_n[47:32];
              if (sh_n[47:32] != 16'h0)
                lst_reg <= L_VEC;
              else if (pc_n == cnt_reg)
              begin
                pat_ok_reg[lch_reg] <= 1'b1;
                lst_reg <= L_IDLE;
              end
              pc_reg <= sh_n[47:32] == 16'h0 ? pc_n : pc_reg;
            end
          end
          L_VEC:
          begin
            if (fc_reg == alws_pkg::VEC_LAST)
            begin
              fc_reg <= '0;
              if (32'(wa_reg) + 32'(cnt_reg) >= DEPTH ||
                  vin.level > alws_pkg::LEVEL_MAX ||
                  vin.level < alws_pkg::LEVEL_MIN)
              begin
                err_reg <= 1'b1;
                lst_reg <= L_IDLE;
              end
              else
              begin
                vmem[lch_reg][AW'(wa_reg)] <= vin;
                wa_reg <= wa_reg + 16'h1;
                vl_reg <= vl_reg - 16'h1;
                if (vl_reg == 16'h1)
                begin
                  pc_reg <= pc_n;
                  lst_reg <= pc_n == cnt_reg ? L_IDLE : L_PAT;
                  if (pc_n == cnt_reg)
                    pat_ok_reg[lch_reg] <= 1'b1;
                end
              end
            end
          end
          L_SENT:
          begin
            if (fc_reg == alws_pkg::SENT_LAST)
            begin
              fc_reg <= '0;
              if (sin.idx == 16'h0 || 32'(sin.idx) > MAXPAT ||
                  sin.rep == 32'h0 || sin.rep > alws_pkg::MAX_REPEAT)
              begin
                err_reg <= 1'b1;
                lst_reg <= L_IDLE;
              end
              else
              begin
                smem[SW'(pc_reg)] <= sin;
                pc_reg <= pc_n;
                if (pc_n == cnt_reg)
                begin
                  nseq_reg <= (SW+1)'(cnt_reg);
                  seq_ok_reg <= 1'b1;
                  seq_done_reg <= 1'b1;
                  lst_reg <= L_IDLE;
                end
              end
            end
          end
          default: lst_reg <= L_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // sequencer shared by all channels
  typedef enum logic [3:0] {
    P_IDLE = 4'b0001,
    P_GAP = 4'b0010,
    P_LAUNCH = 4'b0100,
    P_PLAY = 4'b1000
  } alws_pst_t;

  alws_pst_t pst_reg;
  logic setup_reg, launch_reg, resume_reg;
  logic [SW:0] ent_reg;
  logic [31:0] rep_reg, seqn_reg, dleft_reg;
  logic [2:0] gap_reg;
  logic [PW-1:0] pidx_reg;
  logic [NCH-1:0] done;

  wire logic free = runm_reg == alws_pkg::RUN_FREE;
  wire logic ready = gen_reg == alws_pkg::GEN_ARB && seq_ok_reg &&
                     &pat_ok_reg;
  wire logic [SW:0] ent_n = ent_reg + 1'b1;
  wire logic wrap = ent_n == nseq_reg;
  wire logic [SW:0] nxt = wrap ? '0 : ent_n;
  wire logic [31:0] seqn_n = seqn_reg + 32'h1;
  wire logic go = c_start ? (!running_reg || free) :
                  (c_apply && running_reg && free);

  // stop first, then restarting commands, then normal progress
  always_ff @(posedge mclk or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      pst_reg <= P_IDLE;
      {setup_reg, launch_reg, resume_reg, running_reg} <= '0;
      trig_out <= 1'b0;
      ent_reg <= '0;
      {rep_reg, seqn_reg, dleft_reg} <= '0;
      gap_reg <= '0;
      pidx_reg <= '0;
    end
    else if (ce)
    begin
      setup_reg <= 1'b0;
      launch_reg <= 1'b0;
      trig_out <= 1'b0;
      if (c_stop || c_apply || c_sload ||
          (c_start && running_reg))
      begin
        pst_reg <= P_IDLE;
        running_reg <= 1'b0;
        setup_reg <= 1'b1;
        resume_reg <= c_sload && running_reg && free;
      end
      if (!c_stop && ((go && ready) ||
          (seq_done_reg && resume_reg && ready)))
      begin
        running_reg <= 1'b1;
        ent_reg <= '0;
        rep_reg <= smem[0].rep;
        pidx_reg <= PW'(smem[0].idx - 16'h1);
        {seqn_reg, resume_reg} <= '0;
        dleft_reg <= runp_reg;
        launch_reg <= 1'b1;
        trig_out <= trg_en_reg;
        pst_reg <= P_LAUNCH;
      end
      else if (!(c_stop || c_apply || c_sload || c_start) &&
               running_reg)
      begin
        if (runm_reg == alws_pkg::RUN_DUR &&
            dleft_reg <= alws_pkg::STEP_NS32)
        begin
          running_reg <= 1'b0;
          setup_reg <= 1'b1;
          pst_reg <= P_IDLE;
        end
        else
        begin
          dleft_reg <= dleft_reg - alws_pkg::STEP_NS32;
          unique case (pst_reg)
            P_LAUNCH: pst_reg <= P_PLAY;
            P_GAP:
            begin
              gap_reg <= gap_reg - 3'h1;
              if (gap_reg == 3'h0)
              begin
                launch_reg <= 1'b1;
                trig_out <= trg_en_reg;
                pst_reg <= P_LAUNCH;
              end
            end
            P_PLAY:
            begin
              if (&done && rep_reg > 32'h1)
              begin
                rep_reg <= rep_reg - 32'h1;
                launch_reg <= 1'b1;
                trig_out <= trg_en_reg;
                pst_reg <= P_LAUNCH;
              end
              else if (&done && wrap && runm_reg == alws_pkg::RUN_COUNT
                       && seqn_n >= runp_reg)
              begin
                running_reg <= 1'b0;
                setup_reg <= 1'b1;
                pst_reg <= P_IDLE;
              end
              else if (&done)
              begin
                seqn_reg <= wrap ? seqn_n : seqn_reg;
                ent_reg <= nxt;
                rep_reg <= smem[SW'(nxt)].rep;
                pidx_reg <= PW'(smem[SW'(nxt)].idx - 16'h1);
                if (smem[SW'(nxt)].idx != smem[SW'(ent_reg)].idx)
                begin
                  gap_reg <= alws_pkg::GAP_LOAD;
                  pst_reg <= P_GAP;
                end
                else
                begin
                  launch_reg <= 1'b1;
                  trig_out <= trg_en_reg;
                  pst_reg <= P_LAUNCH;
                end
              end
            end
            default: pst_reg <= P_IDLE;
          endcase
        end
      end
    end
  end

  // status pin mirrors the run flag one flop later
  always_ff @(posedge mclk or negedge rst_s_n)
  begin
    if (!rst_s_n)
      run_status <= 1'b0;
    else if (ce)
      run_status <= running_reg;
  end

  // ==========================================================
  // channel players; a finished channel holds its last level
  for (genvar c = 0; c < NCH; c++)
  begin : g_ch
    logic [AW-1:0] vp_reg;
    logic [15:0] vl_reg;
    logic [30:0] tl_reg;
    logic dn_reg;
    wire alws_pkg::alws_pat_t pat = ptab[c][pidx_reg];
    wire alws_pkg::alws_vec_t v0 = vmem[c][AW'(pat.base)];
    wire alws_pkg::alws_vec_t vn = vmem[c][vp_reg + 1'b1];
    wire logic sw0 = sw_en_reg ? v0.sw : sw_idle_reg;
    wire logic swn = sw_en_reg ? vn.sw : sw_idle_reg;
    assign done[c] = dn_reg;

    always_ff @(posedge mclk or negedge rst_s_n)
    begin
      if (!rst_s_n)
      begin
        vp_reg <= '0;
        vl_reg <= '0;
        tl_reg <= '0;
        dn_reg <= 1'b1;
        ch_out[c] <= '0;
      end
      else if (ce)
      begin
        if (setup_reg && !launch_reg)
        begin
          dn_reg <= 1'b1;
          ch_out[c] <= {ptab[c][PW'(smem[0].idx - 16'h1)].init,
                        31'h0, sw_idle_reg};
        end
        else if (launch_reg)
        begin
          vp_reg <= AW'(pat.base);
          vl_reg <= pat.nvec;
          dn_reg <= pat.nvec == 16'h0;
          tl_reg <= v0.dt;
          if (pat.nvec != 16'h0)
            ch_out[c] <= {v0.level, v0.dt, sw0};
        end
        else if (running_reg && !dn_reg)
        begin
          if (tl_reg > alws_pkg::STEP_NS)
            tl_reg <= tl_reg - alws_pkg::STEP_NS;
          else if (vl_reg == 16'h1)
            dn_reg <= 1'b1;
          else
          begin
            vp_reg <= vp_reg + 1'b1;
            vl_reg <= vl_reg - 16'h1;
            tl_reg <= vn.dt;
            ch_out[c] <= {vn.level, vn.dt, swn};
          end
        end
      end
    end
  end
endmodule

//--- dv/alws_seq_properties.sv
// port checker of the waveform sequencer
// assumes ce drops only with trigger off
`timescale 1ns/1ps
module alws_seq_properties #(
  parameter int NCH = 2
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [31:0] bus_rdata,
  input wire alws_pkg::alws_chout_t [NCH-1:0] ch_out,
  input wire logic trig_out,
  input wire logic run_status
);
  logic [31:0] wd_q1, wd_q2;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // helper: write data two cycles back, for read-back checks
  always_ff @(posedge mclk)
  begin
    wd_q1 <= bus_wdata;
    wd_q2 <= wd_q1;
  end

  // ==========================================================
  // register answers
  sequence s_mode_wr;
    bus_wr && bus_addr == alws_pkg::REG_MODE;
  endsequence
  sequence s_mode_rd;
    bus_rd && bus_addr == alws_pkg::REG_MODE;
  endsequence
  property p_mode_back;
    s_mode_wr ##1 s_mode_rd |=>
      {bus_rdata[5:4], bus_rdata[0]} == {wd_q2[5:4], wd_q2[0]};
  endproperty
  a_mode_back: assert property (p_mode_back)
    else $error("mode read-back differs from write");
  property p_rd_idle;
    !$past(bus_rd) |-> bus_rdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero outside answer cycle");
  property p_stat;
    bus_rd && bus_addr == alws_pkg::REG_STAT |=> bus_rdata[0] == run_status;
  endproperty
  a_stat: assert property (p_stat)
    else $error("status running bit differs from run output");

  // ==========================================================
  // run control and trigger
  property p_trig_pulse;
    trig_out |=> !trig_out;
  endproperty
  a_trig_pulse: assert property (p_trig_pulse)
    else $error("trigger longer than one cycle");
  property p_trig_run;
    trig_out |-> ##[1:2] run_status;
  endproperty
  a_trig_run: assert property (p_trig_run)
    else $error("launch without running status");
  property p_stop;
    bus_wr && bus_addr == alws_pkg::REG_CMD &&
      bus_wdata[3:0] == alws_pkg::CMD_STOP |-> ##[1:3] !run_status;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop command did not end output");
  // idle outputs only move after a register write
  property p_hold;
    !run_status && !$past(run_status) && !$past(run_status, 2) &&
      !$past(bus_wr) && !$past(bus_wr, 2) && !$past(bus_wr, 3)
      |-> $stable(ch_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("channel output moved while waiting");
  property p_trig_idle;
    !run_status && !$past(run_status) && !$past(bus_wr) && !$past(bus_wr, 2)
      |-> !trig_out;
  endproperty
  a_trig_idle: assert property (p_trig_idle)
    else $error("trigger while waiting");
endmodule

bind alws_seq alws_seq_properties #(.NCH(NCH)) u_alws_seq_properties (
  .mclk(mclk), .rst_n(rst_n), .ce(ce), .bus_addr(bus_addr),
  .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .bus_rdata(bus_rdata), .ch_out(ch_out), .trig_out(trig_out),
  .run_status(run_status)
);

//--- dv/alws_host.sv
// host model: register writes, reads and byte-wise load streams
// assumes it is the only master of the register port
`timescale 1ns/1ps
module alws_host (
  input wire logic mclk,
  input wire logic [31:0] bus_rdata,
  output logic [7:0] bus_addr,
  output logic [31:0] bus_wdata,
  output logic bus_wr,
  output logic bus_rd
);
  // ==========================================================
  // bus cycles; strobes stay up until the next call or idle
  initial
  begin
    bus_addr = 8'h00;
    bus_wdata = 32'h0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_wr <= 1'b1;
    bus_rd <= 1'b0;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge mclk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bus_rd <= 1'b1;
    bus_wr <= 1'b0;
    bus_addr <= a;
    @(posedge mclk);
    #1;
    d = bus_rdata;
  endtask
  // released lines flip so stale values cannot look valid
  task automatic idle(input int n);
    bus_wr <= 1'b0;
    bus_rd <= 1'b0;
    bus_addr <= ~bus_addr;
    bus_wdata <= ~bus_wdata;
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // command word, then the stream one byte a write, first byte first
  task automatic send(input logic [31:0] cmd, input logic [7:0] b [$]);
    wr(alws_pkg::REG_CMD, cmd);
    foreach (b[i])
      wr(alws_pkg::REG_LOAD, {24'h0, b[i]});
    idle(2);
  endtask
endmodule

//--- dv/arbitrary_linear_waveform_sequencer_bench.sv
// self-checking bench of the waveform sequencer
// assumes the host model is the only register master; ce dips once
`timescale 1ns/1ps
module arbitrary_linear_waveform_sequencer_bench;
  localparam int NCH = 2;
  logic mclk = 1'b0, rst_n = 1'b0, ce = 1'b1;
  logic [7:0] bus_addr;
  logic [31:0] bus_wdata;
  logic bus_wr, bus_rd;
  logic [31:0] bus_rdata;
  alws_pkg::alws_chout_t [NCH-1:0] ch_out;
  logic trig_out, run_status;
  int err_count = 0, n_compared = 0, ntrig = 0, n0, k;
  logic [31:0] d, prevl, seed = 32'ha26e;
  logic [31:0] ini [NCH], lv1 [NCH], lv2 [NCH];
  logic [7:0] q [$];
  int tt [$];

  alws_seq #(.NCH(NCH)) u_alws_seq (.mclk(mclk), .rst_n(rst_n), .ce(ce),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .ch_out(ch_out),
    .trig_out(trig_out), .run_status(run_status));
  alws_host u_alws_host (.mclk(mclk), .bus_rdata(bus_rdata),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd));

  // ==========================================================
  // clock and launch counter
  always #5 mclk = ~mclk;
  always @(posedge mclk)
    if (trig_out === 1'b1)
      ntrig++;

  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // random level in 1 mV steps inside the legal span
  function automatic logic [31:0] rlev();
    int v;
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    v = int'(seed[15:0] % 16'd40001) * 1000;
    return seed[16] ? -v : v;
  endfunction
  function automatic logic [31:0] mode(input logic [1:0] r);
    return {26'h0, r, 3'h0, alws_pkg::GEN_ARB};
  endfunction
  task automatic put2(input logic [15:0] v);
    q.push_back(v[15:8]);
    q.push_back(v[7:0]);
  endtask
  task automatic put4(input logic [31:0] v);
    put2(v[31:16]);
    put2(v[15:0]);
  endtask
  // header of two sets, one reserved byte may be spoiled
  task automatic hdr(input logic [7:0] rsv);
    q.delete();
    put4(32'h0000_0002);
    put4({rsv, 24'h0});
    repeat (3) put4(32'h0);
  endtask
  task automatic pat(input int c, input logic [7:0] rsv);
    hdr(rsv);
    put2(16'h1);
    put4(ini[c]);
    put4(lv1[c]);
    put4({1'b0, 31'd30});
    put2(16'h1);
    put4(lv2[c]);
    put4(lv2[c]);
    put4({1'b1, 31'd30});
    u_alws_host.send({16'h0, 8'(c), 4'h0, alws_pkg::CMD_PLOAD}, q);
  endtask
  task automatic cmd(input logic [3:0] c);
    u_alws_host.wr(alws_pkg::REG_CMD, {28'h0, c});
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    for (int c = 0; c < NCH; c++)
    begin
      ini[c] = rlev();
      lv1[c] = rlev();
      lv2[c] = rlev();
    end
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    u_alws_host.rd(8'h20, d);
    chk(d, 32'h0);
    u_alws_host.wr(alws_pkg::REG_MODE, mode(alws_pkg::RUN_COUNT));
    u_alws_host.rd(alws_pkg::REG_MODE, d);
    chk(d & 32'h31, mode(alws_pkg::RUN_COUNT));
    pat(0, 8'h01);
    u_alws_host.rd(alws_pkg::REG_STAT, d);
    chk({d[8], d[1]}, 2'b01);
    for (int c = 0; c < NCH; c++)
      pat(c, 8'h00);
    hdr(8'h00);
    put2(16'h1);
    put4(32'h2);
    put2(16'h2);
    put4(32'h1);
    u_alws_host.send({28'h0, alws_pkg::CMD_SLOAD}, q);
    u_alws_host.rd(alws_pkg::REG_STAT, d);
    chk({d[9:8], d[2]}, 3'b111);
    $display("test loads done");
    // one counted sequence: p1, p1, gap, p2
    u_alws_host.wr(alws_pkg::REG_SWCFG, 32'h3);
    u_alws_host.wr(alws_pkg::REG_TRIG, 32'h1);
    u_alws_host.wr(alws_pkg::REG_RUNP, 32'h1);
    cmd(alws_pkg::CMD_APPLY);
    u_alws_host.idle(4);
    for (int c = 0; c < NCH; c++)
      chk(ch_out[c].level, ini[c]);
    cmd(alws_pkg::CMD_START);
    tt.delete();
    for (k = 0; k < 300 && !(k > 3 && run_status === 1'b0); k++)
    begin
      if (ntrig > tt.size())
      begin
        for (int c = 0; c < NCH; c++)
        begin
          chk(ch_out[c].level, tt.size() < 2 ? lv1[c] : lv2[c]);
          chk(ch_out[c].sw, tt.size() == 2);
        end
        if (tt.size() == 2)
          chk(prevl, lv1[0]);
        tt.push_back(k);
      end
      prevl = ch_out[0].level;
      u_alws_host.idle(1);
    end
    if (k == 300)
    begin
      err_count++;
      conclude();
    end
    chk(tt.size(), 3);
    chk((tt[2] - tt[1]) - (tt[1] - tt[0]), 5);
    u_alws_host.idle(2);
    for (int c = 0; c < NCH; c++)
      chk({31'(ch_out[c].level - ini[c]), ch_out[c].sw}, 1);
    u_alws_host.rd(alws_pkg::REG_STAT, d);
    chk(d[0], 1'b0);
    $display("test count run done");
    // free run, trigger off, then restart by apply, then stop
    u_alws_host.wr(alws_pkg::REG_TRIG, 32'h0);
    u_alws_host.wr(alws_pkg::REG_MODE, mode(alws_pkg::RUN_FREE));
    cmd(alws_pkg::CMD_START);
    n0 = ntrig;
    ce <= 1'b0;
    prevl = ch_out[0].level;
    u_alws_host.idle(9);
    chk(ch_out[0].level, prevl);
    ce <= 1'b1;
    u_alws_host.idle(60);
    chk({run_status, 31'(ntrig - n0)}, {1'b1, 31'h0});
    u_alws_host.wr(alws_pkg::REG_TRIG, 32'h1);
    cmd(alws_pkg::CMD_APPLY);
    u_alws_host.idle(40);
    chk({run_status, ntrig > n0}, 2'b11);
    cmd(alws_pkg::CMD_STOP);
    u_alws_host.idle(3);
    chk({run_status, 31'(ch_out[1].level - ini[1])}, 0);
    $display("test free run done");
    // counted run broken by apply waits for a new start
    u_alws_host.wr(alws_pkg::REG_MODE, mode(alws_pkg::RUN_COUNT));
    u_alws_host.wr(alws_pkg::REG_RUNP, 32'd1000);
    cmd(alws_pkg::CMD_START);
    u_alws_host.idle(10);
    cmd(alws_pkg::CMD_APPLY);
    u_alws_host.idle(10);
    chk(run_status, 1'b0);
    $display("test halt done");
    // duration of 500 ns is 50 cycles of output
    u_alws_host.wr(alws_pkg::REG_MODE, mode(alws_pkg::RUN_DUR));
    u_alws_host.wr(alws_pkg::REG_RUNP, 32'd500);
    cmd(alws_pkg::CMD_START);
    u_alws_host.idle(3);
    for (k = 0; k < 200 && run_status === 1'b1; k++)
      u_alws_host.idle(1);
    chk(k >= 44 && k <= 54, 1'b1);
    $display("test duration done");
    conclude();
  end
endmodule
